// [dv/pmon_link_sva.sv]
// checker on the link between the two peak monitor ends
// assumes one clock; the watched signals come from pmon_link_if
`timescale 1ns/100ps
`default_nettype none
module pmon_link_sva (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [pmon_pkg::RA_W-1:0] reg_addr,
    input wire logic [pmon_pkg::RD_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [pmon_pkg::RD_W-1:0] reg_rdata,
    input wire logic [pmon_pkg::WORD_W-1:0] link_word,
    input wire logic link_valid
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    logic [7:0] sh_q [16];
    logic [7:0] sel_q;
    logic [7:0] cfg_q;
    logic [7:0] rd_exp_q;
    logic per_q;
    logic rd_chk_q;
    logic [4:0] fcnt_q;
    logic keep;
    logic routed;
    logic mon;

    // shadow of the writable bytes at monitor_control..0x27F
    assign keep = reg_addr[11:4] == 8'h27 && (reg_addr[3:0] <= 4'h3
        || reg_addr[3:0] == 4'h9 || reg_addr[3:0] == 4'hA);
    assign routed = sh_q[9][1:0] == 2'h3 && sh_q[10][1]
        && sel_q[3:0] == pmon_pkg::CB_SRC_MON && cfg_q[1:0] != 2'h0;
    assign mon = link_word[pmon_pkg::MON_POS];

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 16; i++) begin
                sh_q[i] <= 8'h00;
            end
            sel_q <= 8'h00;
            cfg_q <= 8'h00;
            rd_exp_q <= 8'h00;
            per_q <= 1'h0;
            rd_chk_q <= 1'h0;
            fcnt_q <= 5'h00;
        end else begin
            if (reg_wr && keep)
                sh_q[reg_addr[3:0]] <= reg_wdata;
            if (reg_wr && reg_addr == pmon_pkg::A_CB_SEL0)
                sel_q <= reg_wdata;
            if (reg_wr && reg_addr == pmon_pkg::A_CB_CFG)
                cfg_q <= reg_wdata;
            if (reg_wr && keep && reg_addr[3:0] != 4'h0
                && reg_addr[3:0] <= 4'h3)
                per_q <= 1'h1;
            rd_chk_q <= reg_rd && keep;
            rd_exp_q <= sh_q[reg_addr[3:0]];
            // position of the next monitor bit inside a frame
            if (link_valid) begin
                if (fcnt_q == 5'h00)
                    fcnt_q <= mon ? 5'h01 : 5'h00;
                else
                    fcnt_q <= fcnt_q == 5'h18 ? 5'h00 : fcnt_q + 5'h01;
            end
        end
    end

    property p_strobe_excl;
        !(reg_wr && reg_rd);
    endproperty
    a_strobe_excl: assert property (p_strobe_excl)
        else $error("register strobes overlap");

    property p_strobe_pulse;
        (reg_wr || reg_rd) |=> !(reg_wr || reg_rd);
    endproperty
    a_strobe_pulse: assert property (p_strobe_pulse)
        else $error("register strobe longer than one cycle");

    property p_en_after_period;
        reg_wr && reg_addr == pmon_pkg::A_MON_CTRL
            && reg_wdata[pmon_pkg::BIT_PEAK_EN] |-> per_q;
    endproperty
    a_en_after_period: assert property (p_en_after_period)
        else $error("detection enabled before period written");

    property p_readback;
        rd_chk_q |-> reg_rdata == rd_exp_q;
    endproperty
    a_readback: assert property (p_readback)
        else $error("register read back differs from written value");

    property p_hold_width;
        reg_rd && reg_addr == pmon_pkg::A_HOLD_B1 |=> reg_rdata[7:5] == 3'h0;
    endproperty
    a_hold_width: assert property (p_hold_width)
        else $error("holding value wider than 13 bits");

    property p_low_ctrl_zero;
        link_valid |-> link_word[pmon_pkg::MON_POS-1:0] == 3'h0;
    endproperty
    a_low_ctrl_zero: assert property (p_low_ctrl_zero)
        else $error("lower control bits not zero");

    property p_mon_gated;
        link_valid && mon |-> routed;
    endproperty
    a_mon_gated: assert property (p_mon_gated)
        else $error("monitor bit sent while not routed");

    property p_start_bits;
        link_valid && (fcnt_q == 5'h05 || fcnt_q == 5'h0A
            || fcnt_q == 5'h0F || fcnt_q == 5'h14) |-> mon;
    endproperty
    a_start_bits: assert property (p_start_bits)
        else $error("subframe without start bit");

    c_frame: cover property (link_valid && fcnt_q == 5'h18);
    c_hold_rd: cover property (reg_rd && reg_addr == pmon_pkg::A_HOLD_B0);
    c_enable: cover property (reg_wr && reg_addr == pmon_pkg::A_MON_CTRL);
endmodule : pmon_link_sva
`default_nettype wire

// [dv/tb.sv]
// bench for both peak monitor ends, driven from the software port
// assumes one 50 MHz clock and the fixed read latencies of both ports
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk_sys = 1'h0;
    logic resetn = 1'h0;
    logic ce = 1'h1;
    logic [pmon_pkg::SAMPLE_W-1:0] sample_in = '0;
    logic sample_valid = 1'h0;
    logic [pmon_pkg::SA_W-1:0] sw_addr = '0;
    logic [31:0] sw_wdata = '0;
    logic sw_wr = 1'h0;
    logic sw_rd = 1'h0;
    logic [31:0] sw_rdata;
    logic [pmon_pkg::MAG_W-1:0] peak_out;
    logic peak_stb;
    int fail_count = 0;
    int checks_done = 0;
    int stb_cnt = 0;
    logic cap = 1'h0;
    logic [63:0] mon_bits = '0;
    logic [11:0] up_last = '0;
    logic [31:0] r;
    logic [19:0] d;
    logic [24:0] f;

    pmon_link_if lnk();
    pmon_dev_end pmon_dev_end_i (.clk_sys(clk_sys), .resetn(resetn),
        .ce(ce), .sample_in(sample_in), .sample_valid(sample_valid),
        .lnk(lnk));
    pmon_host_end pmon_host_end_i (.clk_sys(clk_sys), .resetn(resetn),
        .ce(ce), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
        .sw_rd(sw_rd), .sw_rdata(sw_rdata), .peak_out(peak_out),
        .peak_stb(peak_stb), .lnk(lnk));
    pmon_link_sva pmon_link_sva_i (.clk_sys(clk_sys), .resetn(resetn),
        .reg_addr(lnk.reg_addr), .reg_wdata(lnk.reg_wdata),
        .reg_wr(lnk.reg_wr), .reg_rd(lnk.reg_rd),
        .reg_rdata(lnk.reg_rdata), .link_word(lnk.link_word),
        .link_valid(lnk.link_valid));

    always #10 clk_sys = ~clk_sys;

    // wire-side record of monitor bits and sample field
    always @(posedge clk_sys) begin
        if (cap && lnk.link_valid) begin
            mon_bits <= {mon_bits[62:0], lnk.link_word[pmon_pkg::MON_POS]};
            up_last <= lnk.link_word[15:4];
        end
        if (cap && peak_stb)
            stb_cnt++;
    end

    task automatic summarize();
        if (fail_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic sw_write(input logic [7:0] a, input logic [31:0] v);
        sw_addr <= a;
        sw_wdata <= v;
        sw_wr <= 1'h1;
        @(posedge clk_sys);
        sw_wr <= 1'h0;
        @(posedge clk_sys);
    endtask : sw_write

    task automatic sw_read(input logic [7:0] a, output logic [31:0] v);
        sw_addr <= a;
        sw_rd <= 1'h1;
        @(posedge clk_sys);
        sw_rd <= 1'h0;
        @(posedge clk_sys);
        v = sw_rdata;
    endtask : sw_read

    task automatic dwr(input logic [11:0] a, input logic [7:0] v);
        sw_write(pmon_pkg::SA_DEV_ADDR, {20'h0, a});
        sw_write(pmon_pkg::SA_DEV_WDATA, {24'h0, v});
        sw_write(pmon_pkg::SA_CMD, 32'h1);
    endtask : dwr

    task automatic drd(input logic [11:0] a, output logic [31:0] v);
        logic [31:0] t;
        sw_write(pmon_pkg::SA_DEV_ADDR, {20'h0, a});
        sw_write(pmon_pkg::SA_CMD, 32'h2);
        @(posedge clk_sys);
        sw_read(pmon_pkg::SA_DEV_RDATA, t);
        v = {24'h0, t[7:0]};
    endtask : drd

    task automatic rdhold(output logic [31:0] v);
        logic [31:0] lo;
        logic [31:0] hi;
        drd(pmon_pkg::A_HOLD_B0, lo);
        drd(pmon_pkg::A_HOLD_B1, hi);
        v = {19'h0, hi[4:0], lo[7:0]};
    endtask : rdhold

    task automatic setper(input logic [23:0] p);
        dwr(pmon_pkg::A_PER_B0, p[7:0]);
        dwr(pmon_pkg::A_PER_B1, p[15:8]);
        dwr(pmon_pkg::A_PER_B2, p[23:16]);
    endtask : setper

    task automatic smp(input logic [11:0] s);
        sample_in <= s;
        sample_valid <= 1'h1;
        @(posedge clk_sys);
        sample_valid <= 1'h0;
        @(posedge clk_sys);
    endtask : smp

    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        summarize();
    end

    initial begin
        repeat (8) @(posedge clk_sys);
        resetn <= 1'h1;
        repeat (2) @(posedge clk_sys);
        drd(pmon_pkg::A_MON_CTRL, r);
        chk(r, 32'h0);
        rdhold(r);
        chk(r, 32'h0);
        drd(12'h2FF, r);
        chk(r, 32'h0);
        sw_read(8'h1C, r);
        chk(r, 32'h0);
        setper(24'h000003);
        dwr(pmon_pkg::A_MON_CTRL, 8'h01);
        repeat (3) smp(12'h100);
        rdhold(r);
        chk(r, 32'h0);
        dwr(pmon_pkg::A_MON_CTRL, 8'h02);
        @(posedge clk_sys);
        smp(12'h010);
        smp(12'h800);
        smp(12'h7FF);
        rdhold(r);
        chk(r, 32'h800);
        smp(12'h005);
        smp(12'hFFD);
        smp(12'h002);
        rdhold(r);
        chk(r, 32'h005);
        setper(24'h000001);
        dwr(pmon_pkg::A_MON_CTRL, 8'h00);
        dwr(pmon_pkg::A_MON_CTRL, 8'h02);
        @(posedge clk_sys);
        smp(12'h123);
        rdhold(r);
        chk(r, 32'h123);
        smp(12'hFFB);
        rdhold(r);
        chk(r, 32'h005);
        dwr(pmon_pkg::A_MON_CTRL, 8'h00);
        smp(12'h7FF);
        rdhold(r);
        chk(r, 32'h005);
        setper(24'h00001E);
        dwr(pmon_pkg::A_SER_EN, pmon_pkg::SER_EN_MASK);
        dwr(pmon_pkg::A_SER_CTL, 8'h02);
        dwr(pmon_pkg::A_CB_SEL0, {4'h0, pmon_pkg::CB_SRC_MON});
        dwr(pmon_pkg::A_CB_CFG, 8'h01);
        dwr(pmon_pkg::A_MON_CTRL, 8'h02);
        @(posedge clk_sys);
        cap <= 1'h1;
        for (int i = 0; i < 60; i++) begin
            smp(i == 9 ? 12'h5A3 : 12'h011);
        end
        repeat (4) @(posedge clk_sys);
        d = {7'h00, 13'h05A3};
        f = '0;
        for (int i = 0; i < 5; i++) begin
            f = {f[19:0], 1'h1, d[19-4*i -: 4]};
        end
        chk(mon_bits[31:0], {2'h0, f, 5'h00});
        chk(mon_bits[63:32], 32'h0);
        chk({20'h0, up_last}, 32'h011);
        chk({19'h0, peak_out}, 32'h5A3);
        chk(stb_cnt, 32'h1);
        sw_read(pmon_pkg::SA_PEAK, r);
        chk(r, 32'h5A3);
        sw_read(pmon_pkg::SA_FRAMES, r);
        chk(r, 32'h1);
        sw_read(pmon_pkg::SA_STATUS, r);
        chk(r & 32'h3, 32'h1);
        sw_write(pmon_pkg::SA_STATUS, 32'h3);
        sw_read(pmon_pkg::SA_STATUS, r);
        chk(r & 32'h3, 32'h0);
        rdhold(r);
        chk(r, 32'h011);
        summarize();
    end
endmodule : tb
`default_nettype wire

// [rtl/pmon_dev_end.sv]
// peak monitor, converter end: registers, peak detector, link insertion
// assumes sample_valid marks each decimated sample on clk_sys
//
// Implementation choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module pmon_dev_end (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [pmon_pkg::SAMPLE_W-1:0] sample_in,
    input wire logic sample_valid,
    pmon_link_if.dev lnk
);
    typedef struct packed {
        logic [pmon_pkg::RD_W-1:0] mon_ctrl;
        logic [pmon_pkg::PERIOD_W-1:0] period;
        logic [pmon_pkg::RD_W-1:0] ser_en;
        logic [pmon_pkg::RD_W-1:0] ser_ctl;
        logic [pmon_pkg::RD_W-1:0] cb_sel0;
        logic [pmon_pkg::RD_W-1:0] cb_sel1;
        logic [pmon_pkg::RD_W-1:0] cb_cfg;
        logic active;
        logic seed;
        logic [pmon_pkg::PERIOD_W-1:0] timer;
        logic [pmon_pkg::MAG_W-1:0] store;
        logic [pmon_pkg::MAG_W-1:0] hold;
        logic [pmon_pkg::RD_W-1:0] rdata;
        logic [pmon_pkg::WORD_W-1:0] word;
        logic lvalid;
    } pmon_dev_t;

    pmon_dev_t q;
    pmon_dev_t d;

    logic ser_bit;
    logic load_frame;
    logic [pmon_pkg::MAG_W-1:0] mag_now;
    logic [pmon_pkg::MAG_W-1:0] peak_now;
    logic peak_en;
    logic ser_route;
    logic [1:0] cs_num;
    logic [pmon_pkg::TAIL_W-1:0] tail;
    logic [pmon_pkg::RD_W-1:0] rd_mux;

    assign lnk.reg_rdata = q.rdata;
    assign lnk.link_word = q.word;
    assign lnk.link_valid = q.lvalid;

    pmon_frame_tx u_ftx (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ce(ce),
        .load(load_frame),
        .value(d.hold),
        .advance(sample_valid),
        .bit_o(ser_bit)
    );

    assign mag_now = pmon_pkg::mag(sample_in);
    assign peak_en = q.mon_ctrl[pmon_pkg::BIT_PEAK_EN];
    assign cs_num = q.cb_cfg[1:0];

    // monitor serial output reaches the link only when fully enabled
    assign ser_route = ((q.ser_en & pmon_pkg::SER_EN_MASK)
                        == pmon_pkg::SER_EN_MASK)
                       && q.ser_ctl[pmon_pkg::BIT_SER_CTL]
                       && (q.cb_sel0[3:0] == pmon_pkg::CB_SRC_MON);

    // storage is reseeded by the first sample of each period
    always_comb begin
        if (q.seed) begin
            peak_now = mag_now;
        end else begin
            peak_now = pmon_pkg::max_mag(q.store, mag_now);
        end
    end

    // only the monitor bit is placed, at the tail msb; the rest stay zero
    always_comb begin
        tail = '0;
        if (cs_num != pmon_pkg::CB_NONE && ser_route) begin
            tail[pmon_pkg::MON_POS] = ser_bit;
        end
    end

    always_comb begin
        case (lnk.reg_addr)
            pmon_pkg::A_MON_CTRL: begin
                rd_mux = q.mon_ctrl;
            end
            pmon_pkg::A_PER_B0: begin
                rd_mux = q.period[7:0];
            end
            pmon_pkg::A_PER_B1: begin
                rd_mux = q.period[15:8];
            end
            pmon_pkg::A_PER_B2: begin
                rd_mux = q.period[23:16];
            end
            pmon_pkg::A_HOLD_B0: begin
                rd_mux = q.hold[7:0];
            end
            pmon_pkg::A_HOLD_B1: begin
                rd_mux = {3'h0, q.hold[pmon_pkg::MAG_W-1:8]};
            end
            pmon_pkg::A_SER_EN: begin
                rd_mux = q.ser_en;
            end
            pmon_pkg::A_SER_CTL: begin
                rd_mux = q.ser_ctl;
            end
            pmon_pkg::A_CB_SEL0: begin
                rd_mux = q.cb_sel0;
            end
            pmon_pkg::A_CB_SEL1: begin
                rd_mux = q.cb_sel1;
            end
            pmon_pkg::A_CB_CFG: begin
                rd_mux = q.cb_cfg;
            end
            default: begin
                rd_mux = pmon_pkg::RST_BYTE;
            end
        endcase
    end

    always_comb begin
        d = q;
        load_frame = 1'b0;
        if (lnk.reg_rd) begin
            d.rdata = rd_mux;
        end
        if (lnk.reg_wr) begin
            case (lnk.reg_addr)
                pmon_pkg::A_MON_CTRL: begin
                    d.mon_ctrl = lnk.reg_wdata;
                end
                pmon_pkg::A_PER_B0: begin
                    d.period[7:0] = lnk.reg_wdata;
                end
                pmon_pkg::A_PER_B1: begin
                    d.period[15:8] = lnk.reg_wdata;
                end
                pmon_pkg::A_PER_B2: begin
                    d.period[23:16] = lnk.reg_wdata;
                end
                pmon_pkg::A_SER_EN: begin
                    d.ser_en = lnk.reg_wdata;
                end
                pmon_pkg::A_SER_CTL: begin
                    d.ser_ctl = lnk.reg_wdata;
                end
                pmon_pkg::A_CB_SEL0: begin
                    d.cb_sel0 = lnk.reg_wdata;
                end
                pmon_pkg::A_CB_SEL1: begin
                    d.cb_sel1 = lnk.reg_wdata;
                end
                pmon_pkg::A_CB_CFG: begin
                    d.cb_cfg = lnk.reg_wdata;
                end
                default: begin
                end
            endcase
        end
        if (!peak_en) begin
            // timer idle, holding register untouched
            d.active = 1'b0;
        end else if (!q.active) begin
            d.active = 1'b1;
            d.timer = q.period;
            d.seed = 1'b1;
        end else if (sample_valid) begin
            d.store = peak_now;
            d.seed = 1'b0;
            if (q.timer <= pmon_pkg::PERIOD_W'(1)) begin
                d.hold = peak_now;
                // no frame starts while the serial route is off
                load_frame = ser_route;
                d.timer = q.period;
                d.seed = 1'b1;
            end else begin
                d.timer = q.timer - pmon_pkg::PERIOD_W'(1);
            end
        end
        d.lvalid = sample_valid;
        if (sample_valid) begin
            d.word = {sample_in, tail};
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end
endmodule : pmon_dev_end
`default_nettype wire

// [rtl/pmon_frame_tx.sv]
// peak monitor frame serialiser, one bit per advance, msb first
// assumes advance marks one outgoing link sample
`timescale 1ns/100ps
`default_nettype none
module pmon_frame_tx (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    input wire logic load,
    input wire logic [pmon_pkg::MAG_W-1:0] value,
    input wire logic advance,
    output logic bit_o
);
    typedef struct packed {
        logic [pmon_pkg::FRAME_LEN-1:0] sh;
        logic [pmon_pkg::FCNT_W-1:0] cnt;
    } pmon_ftx_t;

    pmon_ftx_t q;
    pmon_ftx_t d;

    // idle line is low between frames
    assign bit_o = (q.cnt != '0) ? q.sh[pmon_pkg::FRAME_LEN-1] : 1'b0;

    always_comb begin
        d = q;
        if (load) begin
            d.sh = pmon_pkg::frame_build(value);
            d.cnt = pmon_pkg::FCNT_W'(pmon_pkg::FRAME_LEN);
        end else if (advance && q.cnt != '0) begin
            d.sh = {q.sh[pmon_pkg::FRAME_LEN-2:0], 1'b0};
            d.cnt = q.cnt - pmon_pkg::FCNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end
endmodule : pmon_frame_tx
`default_nettype wire

// [rtl/pmon_host_end.sv]
// peak monitor, logic-device end: register forwarder and frame rebuild
// assumes device end on the same clk_sys, read data one cycle after strobe
`timescale 1ns/100ps
`default_nettype none
module pmon_host_end (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [pmon_pkg::SA_W-1:0] sw_addr,
    input wire logic [31:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [31:0] sw_rdata,
    output logic [pmon_pkg::MAG_W-1:0] peak_out,
    output logic peak_stb,
    pmon_link_if.host lnk
);
    typedef struct packed {
        logic [pmon_pkg::RA_W-1:0] dev_addr;
        logic [pmon_pkg::RD_W-1:0] dev_wdata;
        logic reg_wr;
        logic reg_rd;
        logic pend;
        logic [pmon_pkg::RD_W-1:0] dev_rdata;
        logic [31:0] rdata;
        logic [pmon_pkg::FRAME_LEN-2:0] sh;
        logic [pmon_pkg::FCNT_W-1:0] cnt;
        logic [pmon_pkg::MAG_W-1:0] peak;
        logic stb;
        logic peak_new;
        logic err;
        logic [15:0] frames;
    } pmon_host_t;

    pmon_host_t q;
    pmon_host_t d;
    logic cbit;
    logic [pmon_pkg::FRAME_LEN-1:0] full;

    assign sw_rdata = q.rdata;
    assign peak_out = q.peak;
    assign peak_stb = q.stb;
    assign lnk.reg_addr = q.dev_addr;
    assign lnk.reg_wdata = q.dev_wdata;
    assign lnk.reg_wr = q.reg_wr;
    assign lnk.reg_rd = q.reg_rd;
    assign cbit = lnk.link_word[pmon_pkg::MON_POS];
    assign full = {q.sh, cbit};

    always_comb begin
        d = q;
        d.reg_wr = 1'b0;
        d.reg_rd = 1'b0;
        d.stb = 1'b0;
        d.pend = q.reg_rd;
        if (q.pend) begin
            d.dev_rdata = lnk.reg_rdata;
        end
        if (sw_rd) begin
            case (sw_addr)
                pmon_pkg::SA_DEV_ADDR: d.rdata = 32'(q.dev_addr);
                pmon_pkg::SA_DEV_WDATA: d.rdata = 32'(q.dev_wdata);
                pmon_pkg::SA_DEV_RDATA: d.rdata = 32'(q.dev_rdata);
                pmon_pkg::SA_STATUS: d.rdata = 32'({q.reg_rd | q.pend,
                                                    q.err, q.peak_new});
                pmon_pkg::SA_PEAK: d.rdata = 32'(q.peak);
                pmon_pkg::SA_FRAMES: d.rdata = 32'(q.frames);
                default: d.rdata = 32'h0000_0000;
            endcase
        end
        if (sw_wr) begin
            case (sw_addr)
                pmon_pkg::SA_DEV_ADDR: d.dev_addr =
                    sw_wdata[pmon_pkg::RA_W-1:0];
                pmon_pkg::SA_DEV_WDATA: d.dev_wdata =
                    sw_wdata[pmon_pkg::RD_W-1:0];
                pmon_pkg::SA_CMD: begin
                    // software orders the writes: period, routing, enable
                    d.reg_wr = sw_wdata[pmon_pkg::CMD_WR];
                    d.reg_rd = sw_wdata[pmon_pkg::CMD_RD]
                               & ~sw_wdata[pmon_pkg::CMD_WR];
                end
                pmon_pkg::SA_STATUS: begin
                    d.peak_new = q.peak_new & ~sw_wdata[pmon_pkg::ST_PEAK];
                    d.err = q.err & ~sw_wdata[pmon_pkg::ST_ERR];
                end
                default: begin
                end
            endcase
        end
        // frame hunt: idle line low, first high bit opens a frame
        if (lnk.link_valid) begin
            if (q.cnt == '0) begin
                if (cbit == pmon_pkg::START_BIT) begin
                    d.sh = (pmon_pkg::FRAME_LEN-1)'(1);
                    d.cnt = pmon_pkg::FCNT_W'(1);
                end
            end else if (q.cnt
                         == pmon_pkg::FCNT_W'(pmon_pkg::FRAME_LEN - 1)) begin
                d.cnt = '0;
                if (pmon_pkg::frame_ok(full)) begin
                    d.peak = pmon_pkg::frame_data(full);
                    d.stb = 1'b1;
                    d.peak_new = 1'b1;
                    d.frames = q.frames + 16'h0001;
                end else begin
                    d.err = 1'b1;
                end
            end else begin
                d.sh = {q.sh[pmon_pkg::FRAME_LEN-3:0], cbit};
                d.cnt = q.cnt + pmon_pkg::FCNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end
endmodule : pmon_host_end
`default_nettype wire

// [rtl/pmon_link_if.sv]
// peak monitor carrier: register port and sample link between the ends
// assumes both ends run on the same clk_sys
`timescale 1ns/100ps
`default_nettype none
interface pmon_link_if;
    logic [pmon_pkg::RA_W-1:0] reg_addr;
    logic [pmon_pkg::RD_W-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [pmon_pkg::RD_W-1:0] reg_rdata;
    logic [pmon_pkg::WORD_W-1:0] link_word;
    logic link_valid;

    modport dev (
        input reg_addr,
        input reg_wdata,
        input reg_wr,
        input reg_rd,
        output reg_rdata,
        output link_word,
        output link_valid
    );
    modport host (
        output reg_addr,
        output reg_wdata,
        output reg_wr,
        output reg_rd,
        input reg_rdata,
        input link_word,
        input link_valid
    );
endinterface : pmon_link_if
`default_nettype wire

// [rtl/pmon_pkg.sv]
// peak signal monitor: shared constants, register map and frame helpers
// assumes one sample clock domain shared by both ends
package pmon_pkg;
    localparam int SAMPLE_W = 12;
    localparam int MAG_W = 13;
    localparam int PERIOD_W = 24;
    localparam int WORD_W = 16;
    localparam int TAIL_W = WORD_W - SAMPLE_W;
    localparam int CTRL_MAX = 3;
    localparam int MON_POS = TAIL_W - 1;
    localparam int RA_W = 12;
    localparam int RD_W = 8;
    localparam int FRAME_LEN = 25;
    localparam int SUB_LEN = 5;
    localparam int SUB_N = 5;
    localparam int DATA_LEN = 20;
    localparam int NIB_W = SUB_LEN - 1;
    localparam int FCNT_W = 5;

    // device register map
    localparam logic [RA_W-1:0] A_MON_CTRL = 12'h270;
    localparam logic [RA_W-1:0] A_PER_B0 = 12'h271;
    localparam logic [RA_W-1:0] A_PER_B1 = 12'h272;
    localparam logic [RA_W-1:0] A_PER_B2 = 12'h273;
    localparam logic [RA_W-1:0] A_HOLD_B0 = 12'h274;
    localparam logic [RA_W-1:0] A_HOLD_B1 = 12'h275;
    localparam logic [RA_W-1:0] A_SER_EN = 12'h279;
    localparam logic [RA_W-1:0] A_SER_CTL = 12'h27A;
    localparam logic [RA_W-1:0] A_CB_SEL0 = 12'h559;
    localparam logic [RA_W-1:0] A_CB_SEL1 = 12'h55A;
    localparam logic [RA_W-1:0] A_CB_CFG = 12'h58F;

    localparam int BIT_PEAK_EN = 1;
    localparam int BIT_SER_CTL = 1;
    localparam logic [RD_W-1:0] SER_EN_MASK = 8'h03;
    localparam logic [3:0] CB_SRC_MON = 4'h3;
    localparam logic [1:0] CB_NONE = 2'h0;
    localparam logic [RD_W-1:0] RST_BYTE = 8'h00;
    localparam logic START_BIT = 1'b1;

    // host software map (byte addresses)
    localparam int SA_W = 8;
    localparam logic [SA_W-1:0] SA_DEV_ADDR = 8'h00;
    localparam logic [SA_W-1:0] SA_DEV_WDATA = 8'h04;
    localparam logic [SA_W-1:0] SA_CMD = 8'h08;
    localparam logic [SA_W-1:0] SA_DEV_RDATA = 8'h0C;
    localparam logic [SA_W-1:0] SA_STATUS = 8'h10;
    localparam logic [SA_W-1:0] SA_PEAK = 8'h14;
    localparam logic [SA_W-1:0] SA_FRAMES = 8'h18;
    localparam int CMD_WR = 0;
    localparam int CMD_RD = 1;
    localparam int ST_PEAK = 0;
    localparam int ST_ERR = 1;
    localparam int ST_BUSY = 2;

    function automatic logic [MAG_W-1:0] mag(
        input logic [SAMPLE_W-1:0] s
    );
        logic [MAG_W-1:0] x;
        x = {s[SAMPLE_W-1], s};
        return s[SAMPLE_W-1] ? (~x) + MAG_W'(1) : x;
    endfunction : mag

    function automatic logic [MAG_W-1:0] max_mag(
        input logic [MAG_W-1:0] a,
        input logic [MAG_W-1:0] b
    );
        return (a > b) ? a : b;
    endfunction : max_mag

    // five subframes, each a start bit and four data bits, msb first
    function automatic logic [FRAME_LEN-1:0] frame_build(
        input logic [MAG_W-1:0] v
    );
        logic [DATA_LEN-1:0] dd;
        logic [FRAME_LEN-1:0] f;
        dd = DATA_LEN'(v);
        f = '0;
        for (int i = 0; i < SUB_N; i++) begin
            f[FRAME_LEN-1-i*SUB_LEN] = START_BIT;
            f[FRAME_LEN-2-i*SUB_LEN -: NIB_W] =
                dd[DATA_LEN-1-i*NIB_W -: NIB_W];
        end
        return f;
    endfunction : frame_build

    function automatic logic frame_ok(input logic [FRAME_LEN-1:0] f);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < SUB_N; i++) begin
            ok = ok & (f[FRAME_LEN-1-i*SUB_LEN] == START_BIT);
        end
        return ok;
    endfunction : frame_ok

    function automatic logic [MAG_W-1:0] frame_data(
        input logic [FRAME_LEN-1:0] f
    );
        logic [DATA_LEN-1:0] dd;
        dd = '0;
        for (int i = 0; i < SUB_N; i++) begin
            dd[DATA_LEN-1-i*NIB_W -: NIB_W] =
                f[FRAME_LEN-2-i*SUB_LEN -: NIB_W];
        end
        return dd[MAG_W-1:0];
    endfunction : frame_data
endpackage : pmon_pkg
